//--- core/atc_timer.sv
// Eight-bit timer/counter with two compare channels and a Wishbone slave
//
// The address map and the Wishbone register port were left to the implementer.
`timescale 1ns/1ps
`include "atc_defines.svh"
module atc_timer (
   input  wire logic             i_clk,
   input  wire logic             i_reset,
   input  wire logic             i_ce,
   input  wire logic             i_wb_cyc,
   input  wire logic             i_wb_stb,
   input  wire logic             i_wb_we,
   input  wire logic [5:0]       i_wb_adr,
   input  wire logic [3:0]       i_wb_sel,
   input  wire logic [31:0]      i_wb_dat,
   output logic      [31:0]      o_wb_dat,
   output logic                  o_wb_ack,
   input  wire logic             i_crystal_in_pin,
   input  wire logic             i_irq_ack_overflow,
   input  wire logic             i_irq_ack_a,
   input  wire logic             i_irq_ack_b,
   output logic                  o_irq_overflow,
   output logic                  o_irq_a,
   output logic                  o_irq_b,
   output atc_pkg::atc_pins_t    o_pins
);
   import atc_pkg::*;

   typedef struct packed {
      atc_ctrl_a_t ctrl_a;
      atc_ctrl_b_t ctrl_b;
      atc_port_t   port;
      logic        async_sel;
      logic [7:0]  count;
      logic        down;
      logic [7:0]  cmp_a;
      logic [7:0]  cmp_b;
      logic [7:0]  buf_a;
      logic [7:0]  buf_b;
      logic        oc_a;
      logic        oc_b;
      logic        block;
      logic [2:0]  flags;
      logic [2:0]  mask;
      logic        ack;
      logic [31:0] rdata;
      logic [2:0]  irq;
      atc_pins_t   pins;
   } atc_state_t;

   atc_state_t st;
   atc_state_t next_st;
   logic       tick;

   atc_tick_gen u_tick (
      .i_clk                (i_clk),
      .i_reset              (i_reset),
      .i_ce                 (i_ce),
      .i_async_clock_select (st.async_sel),
      .i_clock_select_field (st.ctrl_b.clock_select),
      .i_crystal_in_pin     (i_crystal_in_pin),
      .o_tick               (tick)
   );

   function automatic logic is_pwm(input logic [2:0] wgm);
      is_pwm = wgm[0];
   endfunction : is_pwm

   function automatic logic is_fast(input logic [2:0] wgm);
      is_fast = wgm[0] & wgm[1];
   endfunction : is_fast

   // Compare-output action on a match; pwm modes set or clear by polarity and count direction
   function automatic logic match_act(input logic oc, input logic [1:0] com,
                                      input logic pwm, input logic down);
      case (com)
         `ATC_COM_TOGGLE: match_act = pwm ? oc : ~oc;
         `ATC_COM_CLEAR:  match_act = pwm ? down : 1'b0;
         `ATC_COM_SET:    match_act = pwm ? ~down : 1'b1;
         default:         match_act = oc;
      endcase
   endfunction : match_act

   function automatic logic [7:0] lane_merge(input logic [7:0] old, input logic [7:0] wd, input logic en);
      lane_merge = en ? wd : old;
   endfunction : lane_merge

   logic [2:0] wgm;
   logic [7:0] top;
   logic       pwm;
   logic       at_top;
   logic       at_bottom;
   logic       wr;
   logic       rd;
   logic       acc;
   logic       wr_count;
   logic [7:0] wd;

   always_comb begin
      // mode field split over two registers
      wgm       = {st.ctrl_b.wgm_hi, st.ctrl_a.wgm_lo};
      pwm       = is_pwm(wgm);
      // top is max or compare value A
      top       = (wgm == `ATC_WGM_CTC || wgm == `ATC_WGM_PC_OCRA || wgm == `ATC_WGM_FAST_OCRA)
                  ? st.cmp_a : `ATC_MAX;
      at_top    = (st.count == top);
      at_bottom = (st.count == `ATC_BOTTOM);
      acc       = i_wb_cyc & i_wb_stb & ~st.ack;
      wr        = acc & i_wb_we & i_wb_sel[0];
      rd        = acc & ~i_wb_we;
      wd        = i_wb_dat[7:0];
      wr_count  = wr & (i_wb_adr[5:2] == `ATC_ADR_COUNT);
   end

   logic match_a;
   logic match_b;
   logic ov_set;

   always_comb begin
      next_st = st;
      match_a = 1'b0;
      match_b = 1'b0;
      ov_set  = 1'b0;
      next_st.ack = acc;
      next_st.ctrl_b.force_a = 1'b0;
      next_st.ctrl_b.force_b = 1'b0;

      if (tick) begin
         // compare every tick; blocked after a counter write
         match_a = (st.count == st.cmp_a) & ~st.block;
         match_b = (st.count == st.cmp_b) & ~st.block;
         next_st.block = 1'b0;
         if (pwm && !is_fast(wgm)) begin
            if (at_top && !st.down && st.count != `ATC_BOTTOM) begin
               next_st.down  = 1'b1;
               next_st.count = st.count - `ATC_ONE;
            end else if (at_bottom && st.down) begin
               next_st.down  = 1'b0;
               next_st.count = st.count + `ATC_ONE;
               // overflow at bottom in phase correct
               next_st.flags[0] = 1'b1;
               ov_set           = 1'b1;
            end else begin
               next_st.count = st.down ? st.count - `ATC_ONE : st.count + `ATC_ONE;
            end
         end else begin
            next_st.down = 1'b0;
            if (at_top && wgm != `ATC_WGM_NORMAL) begin
               next_st.count = `ATC_BOTTOM;
            end else begin
               next_st.count = st.count + `ATC_ONE;
            end
            if (is_fast(wgm) ? at_top : (st.count == `ATC_MAX)) begin
               next_st.flags[0] = 1'b1;
               ov_set           = 1'b1;
            end
         end
         // buffered update at top (fast) or top (phase correct)
         if (pwm && at_top) begin
            next_st.cmp_a = st.buf_a;
            next_st.cmp_b = st.buf_b;
         end
         if (match_a) next_st.flags[1] = 1'b1;
         if (match_b) next_st.flags[2] = 1'b1;
         // output from match, mode and extremes; state kept otherwise
         if (match_a) next_st.oc_a = match_act(st.oc_a, st.ctrl_a.com_a, pwm, st.down);
         if (match_b) next_st.oc_b = match_act(st.oc_b, st.ctrl_a.com_b, pwm, st.down);
         if (is_fast(wgm) && at_top) begin
            if (st.ctrl_a.com_a[1] && !(st.cmp_a == top)) next_st.oc_a = ~st.ctrl_a.com_a[0];
            if (st.ctrl_a.com_b[1] && !(st.cmp_b == top)) next_st.oc_b = ~st.ctrl_a.com_b[0];
         end
      end

      // cleared on service; a set in the same cycle wins
      // A set in the same cycle wins even when the flag already stands
      if (i_irq_ack_overflow && !ov_set) next_st.flags[0] = 1'b0;
      if (i_irq_ack_a && !match_a) next_st.flags[1] = 1'b0;
      if (i_irq_ack_b && !match_b) next_st.flags[2] = 1'b0;

      if (wr) begin
         case (i_wb_adr[5:2])
            `ATC_ADR_CTRL_A: begin
               next_st.ctrl_a = atc_ctrl_a_t'(wd[7:2]);
            end
            `ATC_ADR_CTRL_B: begin
               next_st.ctrl_b.wgm_hi       = wd[3];
               next_st.ctrl_b.clock_select = wd[2:0];
               // force acts on output only in non-PWM modes
               if (!pwm && wd[7]) next_st.oc_a = match_act(st.oc_a, st.ctrl_a.com_a, 1'b0, 1'b0);
               if (!pwm && wd[6]) next_st.oc_b = match_act(st.oc_b, st.ctrl_a.com_b, 1'b0, 1'b0);
            end
            `ATC_ADR_COUNT: begin
               // CPU access anytime; write wins over count
               next_st.count = wd;
               // block next tick's match, even when stopped
               next_st.block = 1'b1;
            end
            `ATC_ADR_CMP_A: begin
               if (pwm) next_st.buf_a = wd;
               else begin
                  next_st.cmp_a = wd;
                  next_st.buf_a = wd;
               end
            end
            `ATC_ADR_CMP_B: begin
               if (pwm) next_st.buf_b = wd;
               else begin
                  next_st.cmp_b = wd;
                  next_st.buf_b = wd;
               end
            end
            `ATC_ADR_FLAGS: begin
               // write one clears; a same-cycle set wins
               if (wd[0] && !ov_set) next_st.flags[0] = 1'b0;
               if (wd[1] && !match_a) next_st.flags[1] = 1'b0;
               if (wd[2] && !match_b) next_st.flags[2] = 1'b0;
            end
            `ATC_ADR_MASK:  next_st.mask      = wd[2:0];
            `ATC_ADR_ASYNC: next_st.async_sel = wd[0];
            `ATC_ADR_PORT:  next_st.port      = atc_port_t'(wd[3:0]);
            default: ;
         endcase
      end

      next_st.rdata = '0;
      if (rd) begin
         case (i_wb_adr[5:2])
            `ATC_ADR_CTRL_A: next_st.rdata[7:0] = {st.ctrl_a, 2'h0};
            `ATC_ADR_CTRL_B: next_st.rdata[3:0] = {st.ctrl_b.wgm_hi, st.ctrl_b.clock_select};
            `ATC_ADR_COUNT:  next_st.rdata[7:0] = st.count;
            `ATC_ADR_CMP_A:  next_st.rdata[7:0] = pwm ? st.buf_a : st.cmp_a;
            `ATC_ADR_CMP_B:  next_st.rdata[7:0] = pwm ? st.buf_b : st.cmp_b;
            `ATC_ADR_FLAGS:  next_st.rdata[2:0] = st.flags;
            `ATC_ADR_MASK:   next_st.rdata[2:0] = st.mask;
            `ATC_ADR_ASYNC:  next_st.rdata[0]   = st.async_sel;
            `ATC_ADR_PORT:   next_st.rdata[3:0] = st.port;
            default:         next_st.rdata      = '0;
         endcase
      end

      next_st.irq = next_st.flags & next_st.mask;
      // nonzero output mode overrides port value; regardless of waveform mode
      next_st.pins.pin_out[0] = (next_st.ctrl_a.com_a != `ATC_COM_OFF) ? next_st.oc_a : next_st.port.port_out[0];
      next_st.pins.pin_out[1] = (next_st.ctrl_a.com_b != `ATC_COM_OFF) ? next_st.oc_b : next_st.port.port_out[1];
      // direction bit alone drives the enable
      next_st.pins.pin_oe_n = ~next_st.port.dir;
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         st <= '0;
         st.pins.pin_oe_n <= 2'h3;
      end else if (i_ce) begin
         st <= next_st;
      end
   end

   assign o_wb_dat       = st.rdata;
   assign o_wb_ack       = st.ack;
   assign o_irq_overflow = st.irq[0];
   assign o_irq_a        = st.irq[1];
   assign o_irq_b        = st.irq[2];
   assign o_pins         = st.pins;
endmodule : atc_timer

//--- core/atc_defines.svh
// Register map, field positions and constants for the timer/counter
//
// Contract
// - Timer clock is the system clock unless async clock select is set.
// - Counter clears, increments or decrements on each timer tick per mode.
// - Clock select field zero stops the counter.
// - Counter value readable and writable by the CPU at all times.
// - CPU write to counter wins over clear or count in that cycle.
// - Waveform mode is three bits: two in control A, one in control B.
// - Overflow flag set at mode-defined point and can raise an interrupt.
// - Counter equal to compare value sets match flag on the next tick.
// - Enabled match flag requests interrupt; cleared on service or writing one.
// - Output derived from match, waveform mode, output mode, max and bottom.
// - PWM modes double-buffer compare values, updated at top or bottom.
// - CPU compare accesses target buffer when buffered, else compare directly.
// - Force strobe in non-PWM modes acts on output only, no flag or clear.
// - Counter write blocks compare matches in the next timer tick.
// - Output state is kept across waveform mode changes.
// - Output mode field is not buffered; writes act immediately.
// - Nonzero output mode replaces the port output value on the pin.
// - Pin direction stays under the port direction bit.
// - Pin override depends only on output mode, not waveform mode.
// - Top indication at maximum count, bottom indication at zero; the code signals top at compare value A in the modes where A is top.
// - Bottom is 0x00, max is 0xFF, top is max or compare value A.
`ifndef ATC_DEFINES_SVH
`define ATC_DEFINES_SVH
`define ATC_ADR_CTRL_A     4'h0
`define ATC_ADR_CTRL_B     4'h1
`define ATC_ADR_COUNT      4'h2
`define ATC_ADR_CMP_A      4'h3
`define ATC_ADR_CMP_B      4'h4
`define ATC_ADR_FLAGS      4'h5
`define ATC_ADR_MASK       4'h6
`define ATC_ADR_ASYNC      4'h7
`define ATC_ADR_PORT       4'h8
`define ATC_BOTTOM         8'h00
`define ATC_MAX            8'hFF
`define ATC_ONE            8'h01
`define ATC_CS_STOP        3'h0
`define ATC_CS_CRYSTAL     3'h7
`define ATC_COM_OFF        2'h0
`define ATC_COM_TOGGLE     2'h1
`define ATC_COM_CLEAR      2'h2
`define ATC_COM_SET        2'h3
`define ATC_WGM_NORMAL     3'h0
`define ATC_WGM_PC_MAX     3'h1
`define ATC_WGM_CTC        3'h2
`define ATC_WGM_FAST_MAX   3'h3
`define ATC_WGM_PC_OCRA    3'h5
`define ATC_WGM_FAST_OCRA  3'h7
`endif

//--- core/atc_pkg.sv
// Types shared by the timer/counter files
package atc_pkg;
   typedef struct packed {
      logic [1:0] com_a;
      logic [1:0] com_b;
      logic [1:0] wgm_lo;
   } atc_ctrl_a_t;

   typedef struct packed {
      logic       force_a;
      logic       force_b;
      logic       wgm_hi;
      logic [2:0] clock_select;
   } atc_ctrl_b_t;

   typedef struct packed {
      logic [1:0] port_out;
      logic [1:0] dir;
   } atc_port_t;

   typedef struct packed {
      logic [1:0] pin_out;
      logic [1:0] pin_oe_n;
   } atc_pins_t;
endpackage : atc_pkg

//--- core/atc_tick_gen.sv
// Timer tick source: system clock or synchronised crystal edges
`timescale 1ns/1ps
`include "atc_defines.svh"
module atc_tick_gen (
   input  wire logic       i_clk,
   input  wire logic       i_reset,
   input  wire logic       i_ce,
   input  wire logic       i_async_clock_select,
   input  wire logic [2:0] i_clock_select_field,
   input  wire logic       i_crystal_in_pin,
   output logic            o_tick
);
   import atc_pkg::*;

   typedef struct packed {
      logic sync1;
      logic sync2;
      logic prev;
      logic tick;
   } atc_tick_state_t;

   atc_tick_state_t st;
   atc_tick_state_t next_st;

   always_comb begin
      next_st       = st;
      next_st.sync1 = i_crystal_in_pin;
      next_st.sync2 = st.sync1;
      next_st.prev  = st.sync2;
      if (i_clock_select_field == `ATC_CS_STOP) begin
         next_st.tick = 1'b0;
      end else if (i_async_clock_select) begin
         next_st.tick = st.sync2 & ~st.prev;
      end else begin
         next_st.tick = 1'b1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         st <= '0;
      end else if (i_ce) begin
         st <= next_st;
      end
   end

   assign o_tick = st.tick;
endmodule : atc_tick_gen

//--- testbench/atc_timer_chk.sv
// Checker for bus handshake, interrupt masking and pin control
`timescale 1ns/1ps
`include "atc_defines.svh"
module atc_timer_chk
   import atc_pkg::*;
(
   input wire logic               i_clk,
   input wire logic               i_reset,
   input wire logic               i_ce,
   input wire logic               i_wb_cyc,
   input wire logic               i_wb_stb,
   input wire logic               i_wb_we,
   input wire logic [5:0]         i_wb_adr,
   input wire logic [3:0]         i_wb_sel,
   input wire logic [31:0]        i_wb_dat,
   input wire logic [31:0]        o_wb_dat,
   input wire logic               o_wb_ack,
   input wire logic               o_irq_overflow,
   input wire logic               o_irq_a,
   input wire logic               o_irq_b,
   input wire atc_pkg::atc_pins_t o_pins
);
   logic       take;
   logic       wr;
   logic [7:0] sh_ctl;
   logic [7:0] sh_port;
   logic [7:0] sh_mask;
   assign take = i_ce & i_wb_cyc & i_wb_stb & ~o_wb_ack;
   assign wr = take & i_wb_we & i_wb_sel[0];
   // Shadows move on the take edge, as the design's registers do
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         sh_ctl <= 8'h00;
         sh_port <= 8'h00;
         sh_mask <= 8'h00;
      end else if (wr) begin
         if (i_wb_adr[5:2] == `ATC_ADR_CTRL_A) sh_ctl <= i_wb_dat[7:0];
         if (i_wb_adr[5:2] == `ATC_ADR_PORT) sh_port <= i_wb_dat[7:0];
         if (i_wb_adr[5:2] == `ATC_ADR_MASK) sh_mask <= i_wb_dat[7:0];
      end
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_reset);
   AST_ACK_AFTER_TAKE: assert property (take |=> o_wb_ack)
      else $error("ack missing after a taken request");
   AST_ACK_PULSE: assert property (o_wb_ack && i_ce |=> !o_wb_ack)
      else $error("ack longer than one cycle");
   AST_ACK_CAUSE: assert property ($rose(o_wb_ack) |-> $past(i_wb_cyc && i_wb_stb))
      else $error("ack without a request");
   AST_RDATA_IDLE: assert property (!o_wb_ack |-> o_wb_dat == 32'h0)
      else $error("read data not zero outside ack");
   // Shadows and design registers move on the same edge, so no $past here
   AST_IRQ_MASK: assert property (({o_irq_b, o_irq_a, o_irq_overflow} & ~sh_mask[2:0]) == 3'h0)
      else $error("interrupt raised while masked");
   AST_PIN_DIR: assert property (o_pins.pin_oe_n == ~sh_port[1:0])
      else $error("pin enable differs from direction bits");
   AST_PIN_PORT_A: assert property (sh_ctl[7:6] == 2'h0 |-> o_pins.pin_out[0] == sh_port[2])
      else $error("channel A pin not from port value");
   AST_PIN_PORT_B: assert property (sh_ctl[5:4] == 2'h0 |-> o_pins.pin_out[1] == sh_port[3])
      else $error("channel B pin not from port value");
   cover property (wr && i_wb_adr[5:2] == `ATC_ADR_COUNT);
   cover property ($rose(o_irq_a));
   cover property (o_pins.pin_oe_n == 2'h0);
endmodule : atc_timer_chk

//--- testbench/atc_cpu_model.sv
// CPU side: classic Wishbone master and interrupt service strobes
`timescale 1ns/1ps
module atc_cpu_model (
   input  wire logic        i_clk,
   input  wire logic [31:0] i_wb_dat,
   input  wire logic        i_wb_ack,
   output logic             o_wb_cyc,
   output logic             o_wb_stb,
   output logic             o_wb_we,
   output logic [5:0]       o_wb_adr,
   output logic [3:0]       o_wb_sel,
   output logic [31:0]      o_wb_dat,
   output logic [2:0]       o_irq_ack
);
   initial begin
      o_wb_cyc = 1'b0;
      o_wb_stb = 1'b0;
      o_wb_we = 1'b0;
      o_wb_adr = 6'h00;
      o_wb_sel = 4'h0;
      o_wb_dat = 32'h0;
      o_irq_ack = 3'h0;
   end
   // Gap gives a slow CPU; request held until ack is sampled high
   task automatic access(input logic we, input logic [3:0] idx, input logic [7:0] d, input int gap,
                         output logic [7:0] q);
      int n;
      n = 0;
      repeat (gap + 1) @(posedge i_clk);
      o_wb_cyc <= 1'b1;
      o_wb_stb <= 1'b1;
      o_wb_we <= we;
      o_wb_adr <= {idx, 2'b00};
      o_wb_sel <= 4'hF;
      o_wb_dat <= {24'h0, d};
      do begin
         @(posedge i_clk);
         n++;
      end while (i_wb_ack !== 1'b1 && n < 1000);
      q = i_wb_dat[7:0];
      o_wb_cyc <= 1'b0;
      o_wb_stb <= 1'b0;
      // Released bus shows inverted address and data, not their stale values
      o_wb_adr <= ~o_wb_adr;
      o_wb_dat <= ~o_wb_dat;
   endtask : access
   task automatic service(input int which);
      @(posedge i_clk);
      o_irq_ack[which] <= 1'b1;
      @(posedge i_clk);
      o_irq_ack <= 3'h0;
   endtask : service
endmodule : atc_cpu_model

//--- testbench/atc_timer_bench.sv
// Self-checking bench for the timer/counter
`timescale 1ns/1ps
`include "atc_defines.svh"
module atc_timer_bench;
   import atc_pkg::*;
   logic        i_clk = 1'b0;
   logic        i_reset = 1'b1;
   logic        xtal = 1'b0;
   logic        ce = 1'b1;
   logic        cyc, stb, we, ack, irq_ov, irq_a, irq_b;
   logic [5:0]  adr;
   logic [3:0]  sel;
   logic [31:0] wdat, rdat;
   logic [2:0]  irq_ack;
   atc_pins_t   pins;
   logic [31:0] lfsr = 32'h37254155;
   logic [7:0]  q, q1, v;
   logic [3:0]  addrs [7] = '{`ATC_ADR_CTRL_A, `ATC_ADR_COUNT, `ATC_ADR_CMP_A, `ATC_ADR_CMP_B,
                              `ATC_ADR_MASK, `ATC_ADR_PORT, 4'hB};
   int          error_cnt = 0;
   int          tests_run = 0;
   int          n;
   always #5 i_clk = ~i_clk;
   atc_timer atc_timer_inst (.i_clk(i_clk), .i_reset(i_reset), .i_ce(ce), .i_wb_cyc(cyc), .i_wb_stb(stb),
      .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
      .i_crystal_in_pin(xtal), .i_irq_ack_overflow(irq_ack[0]), .i_irq_ack_a(irq_ack[1]),
      .i_irq_ack_b(irq_ack[2]), .o_irq_overflow(irq_ov), .o_irq_a(irq_a), .o_irq_b(irq_b), .o_pins(pins));
   atc_cpu_model atc_cpu_model_inst (.i_clk(i_clk), .i_wb_dat(rdat), .i_wb_ack(ack), .o_wb_cyc(cyc),
      .o_wb_stb(stb), .o_wb_we(we), .o_wb_adr(adr), .o_wb_sel(sel), .o_wb_dat(wdat), .o_irq_ack(irq_ack));
   function automatic logic [7:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr[7:0];
   endfunction : rnd
   function automatic logic [7:0] rmask(input logic [3:0] a);
      case (a)
         `ATC_ADR_CTRL_A: return 8'hFC;
         `ATC_ADR_MASK: return 8'h07;
         `ATC_ADR_PORT: return 8'h0F;
         4'hB: return 8'h00;
         default: return 8'hFF;
      endcase
   endfunction : rmask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      atc_cpu_model_inst.access(1'b1, a, d, 0, q);
   endtask : wr
   task automatic rd(input logic [3:0] a);
      atc_cpu_model_inst.access(1'b0, a, 8'h00, 0, q);
   endtask : rd
   task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
      rd(a);
      chk({24'h0, q}, {24'h0, e});
   endtask : rd_chk
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : summarize
   initial begin
      repeat (20000) @(posedge i_clk);
      error_cnt++;
      summarize();
   end
   initial begin
      repeat (16) @(posedge i_clk);
      i_reset <= 1'b0;
      for (int a = 0; a < 16; a++) rd_chk(a[3:0], 8'h00);
      foreach (addrs[i]) begin
         v = rnd();
         atc_cpu_model_inst.access(1'b1, addrs[i], v, int'(rnd() % 3), q);
         rd_chk(addrs[i], v & rmask(addrs[i]));
      end
      wr(`ATC_ADR_CTRL_A, 8'h00);
      wr(`ATC_ADR_PORT, 8'h00);
      v = rnd();
      wr(`ATC_ADR_COUNT, v);
      repeat (20) @(posedge i_clk);
      rd_chk(`ATC_ADR_COUNT, v);
      wr(`ATC_ADR_CTRL_B, 8'h01);
      rd(`ATC_ADR_COUNT);
      q1 = q;
      rd(`ATC_ADR_COUNT);
      chk({24'h0, q - q1}, 32'h3);
      // Clock enable low for ten cycles must freeze the count
      q1 = q;
      ce <= 1'b0;
      repeat (10) @(posedge i_clk);
      ce <= 1'b1;
      rd(`ATC_ADR_COUNT);
      chk({24'h0, q - q1}, 32'h3);
      wr(`ATC_ADR_COUNT, v);
      rd_chk(`ATC_ADR_COUNT, v + 8'h02);
      wr(`ATC_ADR_CTRL_B, 8'h00);
      wr(`ATC_ADR_CMP_A, 8'hFC);
      wr(`ATC_ADR_CMP_B, 8'h02 | (rnd() & 8'h03));
      wr(`ATC_ADR_COUNT, 8'hF8);
      wr(`ATC_ADR_MASK, 8'h07);
      wr(`ATC_ADR_FLAGS, 8'h07);
      wr(`ATC_ADR_CTRL_B, 8'h01);
      repeat (24) @(posedge i_clk);
      wr(`ATC_ADR_CTRL_B, 8'h00);
      rd_chk(`ATC_ADR_FLAGS, 8'h07);
      chk({29'h0, irq_b, irq_a, irq_ov}, 32'h7);
      atc_cpu_model_inst.service(0);
      rd_chk(`ATC_ADR_FLAGS, 8'h06);
      wr(`ATC_ADR_FLAGS, 8'h02);
      rd_chk(`ATC_ADR_FLAGS, 8'h04);
      wr(`ATC_ADR_MASK, 8'h00);
      chk({29'h0, irq_b, irq_a, irq_ov}, 32'h0);
      wr(`ATC_ADR_CMP_A, 8'h40);
      wr(`ATC_ADR_COUNT, 8'h40);
      wr(`ATC_ADR_FLAGS, 8'h07);
      wr(`ATC_ADR_CTRL_B, 8'h01);
      wr(`ATC_ADR_CTRL_B, 8'h00);
      rd_chk(`ATC_ADR_FLAGS, 8'h00);
      wr(`ATC_ADR_COUNT, 8'h10);
      wr(`ATC_ADR_CTRL_A, 8'h70);
      wr(`ATC_ADR_CTRL_B, 8'hC0);
      wr(`ATC_ADR_PORT, 8'h03);
      repeat (3) @(posedge i_clk);
      chk({28'h0, pins}, 32'hC);
      wr(`ATC_ADR_CTRL_B, 8'hC0);
      repeat (3) @(posedge i_clk);
      chk({28'h0, pins}, 32'h8);
      rd_chk(`ATC_ADR_FLAGS, 8'h00);
      rd_chk(`ATC_ADR_COUNT, 8'h10);
      wr(`ATC_ADR_CTRL_A, 8'h7C);
      repeat (3) @(posedge i_clk);
      chk({28'h0, pins}, 32'h8);
      wr(`ATC_ADR_CTRL_A, 8'h00);
      wr(`ATC_ADR_PORT, 8'h07);
      repeat (3) @(posedge i_clk);
      chk({28'h0, pins}, 32'h4);
      wr(`ATC_ADR_PORT, 8'h04);
      repeat (3) @(posedge i_clk);
      chk({28'h0, pins}, 32'h7);
      wr(`ATC_ADR_COUNT, 8'h00);
      wr(`ATC_ADR_ASYNC, 8'h01);
      wr(`ATC_ADR_CTRL_B, 8'h07);
      n = int'(rnd() % 6) + 2;
      repeat (n) begin
         repeat (5) @(posedge i_clk);
         xtal <= 1'b1;
         repeat (5) @(posedge i_clk);
         xtal <= 1'b0;
      end
      repeat (10) @(posedge i_clk);
      wr(`ATC_ADR_CTRL_B, 8'h00);
      rd_chk(`ATC_ADR_COUNT, n[7:0]);
      wr(`ATC_ADR_ASYNC, 8'h00);
      summarize();
   end
endmodule : atc_timer_bench
bind atc_timer atc_timer_chk atc_timer_chk_inst (.i_clk(i_clk), .i_reset(i_reset), .i_ce(i_ce),
   .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel),
   .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_irq_overflow(o_irq_overflow),
   .o_irq_a(o_irq_a), .o_irq_b(o_irq_b), .o_pins(o_pins));
